// ---- hdl/sbsr_pkg.sv ----
package sbsr_pkg;

  // ***************************************************************
  // Sizes and timing
  // ***************************************************************
  // Width of one transferred word.
  localparam int WORD_W = 18;
  // Width of the shared address pins.
  localparam int ADDR_W = 8;
  // Transfers in one burst.
  localparam int BURST_LEN = 2;
  // Half cycles of read latency with the loop enabled (one and a half).
  localparam logic [2:0] LAT_HALF_PLL = 3'h3;
  // Half cycles of read latency in legacy mode (one cycle).
  localparam logic [2:0] LAT_HALF_LEGACY = 3'h2;

  // ***************************************************************
  // Carried groups
  // ***************************************************************
  // Control inputs captured from the controller.
  typedef struct packed {
    logic rd_sel_n;
    logic wr_sel_n;
    logic [1:0] lane_mask_n;
  } sbsr_ctrl_s;

  // Read port pin group: data, enable.
  typedef struct packed {
    logic [WORD_W-1:0] data;
    logic oe;
  } sbsr_rdbus_s;

endpackage

// ---- hdl/sbsr_sync.sv ----
`timescale 1ns/1ps
// Two flip-flop synchroniser for a group of pin levels.
module sbsr_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  // The first stage is read only by the second stage.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule

// ---- hdl/sbsr_core.sv ----
`timescale 1ns/1ps
// Operation
// - Separate read-only and write-only data ports.
// - Read and write addresses share address pins.
// - Loop enabled: read latency one and half.
// - Loop bypassed: read latency one cycle.
// - Accesses start only on positive strobe rise.
// - Outputs timed from output strobes, else input.
// - Write data captured on input strobe edges.
// - Read data launched on output strobe rises.
// - Selects and lane masks registered before use.
// - Two arrays, burst of two words.
// - Two transfers per strobe cycle.
// - Read starts with select low at rise.
// - Read address held for the burst.
// - Loop enabled: first word follows negative output strobe.
// - Loop enabled: second word on positive output strobe.
// - Bus released after last word, no waits.
// - Bypass low disables loop, legacy timing.
module sbsr_core #(
  parameter int WORD_W = sbsr_pkg::WORD_W,
  parameter int ADDR_W = sbsr_pkg::ADDR_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_strobe_pos,
  input wire logic in_strobe_neg,
  input wire logic out_strobe_pos,
  input wire logic out_strobe_neg,
  input wire logic single_clk_mode,
  input wire logic pll_bypass_n,
  input wire logic rd_port_sel_n,
  input wire logic wr_port_sel_n,
  input wire logic [1:0] lane_write_mask_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [WORD_W-1:0] wr_bus,
  output logic [WORD_W-1:0] rd_bus,
  output logic rd_bus_oe
);

  // ***************************************************************
  // Pin synchronisers
  // ***************************************************************
  localparam int SW = 10 + ADDR_W + WORD_W;
  localparam int HALF_W = WORD_W / 2;
  logic [SW-1:0] raw_in;
  logic [SW-1:0] syn;
  logic kp_s, kn_s, cp_s, cn_s, mode_s, byp_n_s;
  logic [ADDR_W-1:0] addr_s;
  logic [WORD_W-1:0] wd_s;
  sbsr_pkg::sbsr_ctrl_s ctrl_s;

  // Every pin passes two flip-flops before any logic reads it.
  assign raw_in = {in_strobe_pos, in_strobe_neg, out_strobe_pos,
                   out_strobe_neg, single_clk_mode, pll_bypass_n,
                   rd_port_sel_n, wr_port_sel_n, lane_write_mask_n,
                   addr, wr_bus};

  sbsr_sync #(.W(SW)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d(raw_in),
    .q(syn)
  );

  // Unpack the synchronised pin levels.
  assign {kp_s, kn_s, cp_s, cn_s, mode_s, byp_n_s, ctrl_s, addr_s,
          wd_s} = syn;

  // ***************************************************************
  // Edge detection state
  // ***************************************************************
  logic kp_q, kn_q, cp_q, cn_q;
  logic kp_rise, kn_rise, cp_rise, cn_rise;
  logic ref_pos_rise, ref_neg_rise;

  // Previous strobe levels for edge finding.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      kp_q <= 1'b0;
      kn_q <= 1'b0;
      cp_q <= 1'b0;
      cn_q <= 1'b0;
    end else begin
      kp_q <= kp_s;
      kn_q <= kn_s;
      cp_q <= cp_s;
      cn_q <= cn_s;
    end
  end

  // Rising edges of all four strobes.
  assign kp_rise = kp_s & ~kp_q;
  assign kn_rise = kn_s & ~kn_q;
  assign cp_rise = cp_s & ~cp_q;
  assign cn_rise = cn_s & ~cn_q;

  assign ref_pos_rise = mode_s ? kp_rise : cp_rise;
  assign ref_neg_rise = mode_s ? kn_rise : cn_rise;

  // ***************************************************************
  // Memory arrays and write port
  // ***************************************************************
  logic [WORD_W-1:0] mem_lo [0:(1<<ADDR_W)-1];
  logic [WORD_W-1:0] mem_hi [0:(1<<ADDR_W)-1];
  sbsr_pkg::sbsr_ctrl_s ctrl_q, ctrl_d;
  logic [WORD_W-1:0] wlo_q, wlo_d;
  logic wpend_q, wpend_d;
  logic wlo_en, whi_en;

  // Controls registered on input strobe rises.
  always_comb begin
    ctrl_d = ctrl_q;
    if (kp_rise || kn_rise) begin
      ctrl_d = ctrl_s;
    end
  end

  // Write capture: first word on positive, address and second
  // word on negative strobe, as the shared pins are split by slot.
  always_comb begin
    wlo_d = wlo_q;
    wpend_d = wpend_q;
    if (kp_rise) begin
      wpend_d = ~ctrl_s.wr_sel_n;
      if (!ctrl_s.wr_sel_n) begin
        wlo_d = wd_s;
      end
    end else if (kn_rise && wpend_q) begin
      // Write address is taken in its own slot by the array write.
      wpend_d = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= '1;
      wlo_q <= '0;
      wpend_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      wlo_q <= wlo_d;
      wpend_q <= wpend_d;
    end
  end

  // Both array words written at the second slot.
  assign wlo_en = kn_rise && wpend_q;
  assign whi_en = kn_rise && wpend_q;

  always_ff @(posedge clk) begin
    if (wlo_en) begin
      if (!ctrl_q.lane_mask_n[0]) mem_lo[addr_s][HALF_W-1:0] <=
          wlo_q[HALF_W-1:0];
      if (!ctrl_q.lane_mask_n[1]) mem_lo[addr_s][WORD_W-1:HALF_W] <=
          wlo_q[WORD_W-1:HALF_W];
    end
    if (whi_en) begin
      if (!ctrl_s.lane_mask_n[0]) mem_hi[addr_s][HALF_W-1:0] <=
          wd_s[HALF_W-1:0];
      if (!ctrl_s.lane_mask_n[1]) mem_hi[addr_s][WORD_W-1:HALF_W] <=
          wd_s[WORD_W-1:HALF_W];
    end
  end

  // ***************************************************************
  // Read sequencer
  // ***************************************************************
  typedef enum logic [1:0] {
    RD_IDLE,
    RD_WAIT,
    RD_WORD0,
    RD_WORD1
  } sbsr_rd_e;

  sbsr_rd_e st_q, st_d;
  logic [ADDR_W-1:0] raddr_q, raddr_d;
  logic [WORD_W-1:0] rd_q, rd_d;
  logic oe_q, oe_d;
  logic armed_q, armed_d;
  logic start;

  // Read start: select low at a positive input rise.
  assign start = kp_rise && !ctrl_s.rd_sel_n;

  // The read port only ever drives its own output bus.
  always_comb begin
    st_d = st_q;
    raddr_d = raddr_q;
    rd_d = rd_q;
    oe_d = oe_q;
    armed_d = armed_q;
    case (st_q)
      RD_IDLE: begin
        if (start) begin
          raddr_d = addr_s;
          armed_d = 1'b0;
          st_d = RD_WAIT;
        end
      end
      RD_WAIT: begin
        // Legacy launch on positive reference rise.
        if (!byp_n_s && ref_pos_rise) begin
          rd_d = mem_lo[raddr_q];
          oe_d = 1'b1;
          st_d = RD_WORD0;
        // First word on the negative reference rise that
        // follows the next positive input rise, one and a half cycles.
        end else if (byp_n_s && armed_q && ref_neg_rise) begin
          rd_d = mem_lo[raddr_q];
          oe_d = 1'b1;
          armed_d = 1'b0;
          st_d = RD_WORD0;
        end else if (kp_rise) begin
          armed_d = 1'b1;
        end
      end
      RD_WORD0: begin
        // Second word on the opposite reference.
        if ((byp_n_s && ref_pos_rise) || (!byp_n_s && ref_neg_rise)) begin
          rd_d = mem_hi[raddr_q];
          st_d = RD_WORD1;
        end
      end
      RD_WORD1: begin
        // Release or chain into a queued burst.
        if ((byp_n_s && ref_neg_rise) || (!byp_n_s && ref_pos_rise)) begin
          oe_d = 1'b0;
          rd_d = '0;
          st_d = RD_IDLE;
        end
        if (start) begin
          raddr_d = addr_s;
          armed_d = 1'b0;
          st_d = RD_WAIT;
        end
      end
      default: begin
        st_d = RD_IDLE;
        oe_d = 1'b0;
        armed_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= RD_IDLE;
      raddr_q <= '0;
      rd_q <= '0;
      oe_q <= 1'b0;
      armed_q <= 1'b0;
    end else begin
      st_q <= st_d;
      raddr_q <= raddr_d;
      rd_q <= rd_d;
      oe_q <= oe_d;
      armed_q <= armed_d;
    end
  end

  // Read bus comes straight from output registers.
  assign rd_bus = rd_q;
  assign rd_bus_oe = oe_q;

  // ***************************************************************
  // Checks
  // ***************************************************************
  // Idle port keeps bus released.
  idle_release_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (st_q == RD_IDLE) |-> !rd_bus_oe)
    else $error("read bus driven while idle");

  read_start_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (st_q == RD_IDLE && start) |=> (st_q == RD_WAIT))
    else $error("read start not taken");

  addr_hold_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (st_q == RD_WORD0) |=> $stable(raddr_q))
    else $error("read address changed in burst");

  // Enable rises only via first word.
  first_word_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    $rose(rd_bus_oe) |-> (st_q == RD_WORD0))
    else $error("bus enabled outside first word");

  second_word_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (st_q == RD_WORD1) |-> $past(st_q) inside {RD_WORD0, RD_WORD1})
    else $error("second word out of order");

  bus_release_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    $fell(rd_bus_oe) |-> $past(st_q) == RD_WORD1)
    else $error("bus released early");

  // Loop mode launches on negative reference.
  pll_launch_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (st_q == RD_WAIT && byp_n_s && armed_q && ref_neg_rise) |=> rd_bus_oe)
    else $error("late first word in loop mode");

  legacy_launch_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (st_q == RD_WAIT && !byp_n_s && ref_pos_rise) |=> rd_bus_oe)
    else $error("late first word in legacy mode");

  // Controls change only at input rises.
  ctrl_reg_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    !$past(kp_rise) && !$past(kn_rise) |-> $stable(ctrl_q))
    else $error("control register changed off edge");

endmodule

// ---- sim/sbsr_host_model.sv ----
`timescale 1ns/1ps
// Host controller model: free running strobes, one command per period.
module sbsr_host_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic out_stop,
  output logic in_strobe_pos,
  output logic in_strobe_neg,
  output logic out_strobe_pos,
  output logic out_strobe_neg,
  output logic rd_port_sel_n,
  output logic wr_port_sel_n,
  output logic [1:0] lane_write_mask_n,
  output logic [sbsr_pkg::ADDR_W-1:0] addr,
  output logic [sbsr_pkg::WORD_W-1:0] wr_bus
);
  logic [3:0] cnt_q;

  // ***************************************************************
  // Strobes and command phases
  // ***************************************************************
  // Phase counter; one strobe period lasts sixteen clocks.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end

  // Complementary strobe pairs; the output pair can be frozen low.
  assign in_strobe_pos = ~cnt_q[3];
  assign in_strobe_neg = cnt_q[3];
  assign out_strobe_pos = ~cnt_q[3] & ~out_stop;
  assign out_strobe_neg = cnt_q[3] & ~out_stop;

  // Both ports idle at time zero.
  initial begin
    rd_port_sel_n = 1'b1;
    wr_port_sel_n = 1'b1;
    lane_write_mask_n = 2'h3;
    addr = 8'h00;
    wr_bus = 18'h00000;
  end

  // One command: setup four clocks before each strobe rise, held after.
  task automatic issue(input logic rd, input logic wr,
                       input logic [7:0] ra, input logic [7:0] wa,
                       input logic [17:0] w0, input logic [17:0] w1,
                       input logic [1:0] m);
    do @(posedge clk); while (cnt_q != 4'hB);
    rd_port_sel_n <= ~rd;
    wr_port_sel_n <= ~wr;
    addr <= ra;
    wr_bus <= w0;
    lane_write_mask_n <= m;
    repeat (8) @(posedge clk);
    rd_port_sel_n <= 1'b1;
    wr_port_sel_n <= 1'b1;
    addr <= wa;
    wr_bus <= w1;
    repeat (8) @(posedge clk);
    addr <= ~wa;
    wr_bus <= ~w1;
    lane_write_mask_n <= ~m;
  endtask
endmodule

// ---- sim/tb_top.sv ----
`timescale 1ns/1ps
// Self-checking bench for the split port burst read core.
module tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic single_clk_mode = 1'b0;
  logic pll_bypass_n = 1'b1;
  logic out_stop = 1'b0;
  logic isp, isn, osp, osn, rsel_n, wsel_n, oe;
  logic [1:0] mask_n;
  logic [7:0] addr;
  logic [17:0] wr_bus, rd_bus, exp0, exp1;
  int errors = 0;
  int n_checks = 0;

  // ***************************************************************
  // Clock, host model and design
  // ***************************************************************
  // Free running 100 MHz clock.
  always #5 clk = ~clk;

  sbsr_host_model u_host (.clk(clk), .rst_n(rst_n), .out_stop(out_stop),
    .in_strobe_pos(isp), .in_strobe_neg(isn), .out_strobe_pos(osp),
    .out_strobe_neg(osn), .rd_port_sel_n(rsel_n), .wr_port_sel_n(wsel_n),
    .lane_write_mask_n(mask_n), .addr(addr), .wr_bus(wr_bus));

  sbsr_core dut (.clk(clk), .rst_n(rst_n), .in_strobe_pos(isp),
    .in_strobe_neg(isn), .out_strobe_pos(osp), .out_strobe_neg(osn),
    .single_clk_mode(single_clk_mode), .pll_bypass_n(pll_bypass_n),
    .rd_port_sel_n(rsel_n), .wr_port_sel_n(wsel_n),
    .lane_write_mask_n(mask_n), .addr(addr), .wr_bus(wr_bus),
    .rd_bus(rd_bus), .rd_bus_oe(oe));

  // Compares one value and counts the outcome.
  task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Lane merge for an active low two lane write mask.
  function automatic logic [17:0] merge(input logic [17:0] o,
                                        input logic [17:0] n,
                                        input logic [1:0] m);
    return {m[1] ? o[17:9] : n[17:9], m[0] ? o[8:0] : n[8:0]};
  endfunction

  // One strobe period of traffic, then the read burst is judged.
  task automatic xfer(input logic rd, input logic wr, input logic [7:0] ra,
                      input logic [7:0] wa, input logic [17:0] w0,
                      input logic [17:0] w1, input logic [1:0] m);
    int off;
    u_host.issue(rd, wr, ra, wa, w0, w1, m);
    // The mode is read once the command is out: a caller may have set
    // it by a non-blocking assignment in the time step of the call.
    off = pll_bypass_n ? 8 : 0;
    chk({17'h0, oe}, 18'h0);
    repeat (10 + off) @(posedge clk);
    chk({17'h0, oe}, {17'h0, rd});
    chk(rd_bus, rd ? exp0 : 18'h0);
    repeat (8) @(posedge clk);
    chk(rd_bus, rd ? exp1 : 18'h0);
    repeat (8) @(posedge clk);
    chk({17'h0, oe}, 18'h0);
    chk(rd_bus, 18'h0);
  endtask

  // Full write then read back with the loop enabled.
  task automatic s_basic();
    xfer(1'b0, 1'b1, 8'h00, 8'h05, 18'h2A5C3, 18'h15A3C, 2'h0);
    exp0 = 18'h2A5C3;
    exp1 = 18'h15A3C;
    xfer(1'b1, 1'b0, 8'h05, 8'h00, 18'h0, 18'h0, 2'h3);
  endtask

  // Legacy mode with a concurrent read and write on shared pins.
  task automatic s_legacy();
    @(posedge clk) pll_bypass_n <= 1'b0;
    xfer(1'b1, 1'b1, 8'h05, 8'hFF, 18'h3FFFF, 18'h00001, 2'h0);
    exp0 = 18'h3FFFF;
    exp1 = 18'h00001;
    xfer(1'b1, 1'b0, 8'hFF, 8'h00, 18'h0, 18'h0, 2'h3);
    @(posedge clk) pll_bypass_n <= 1'b1;
  endtask

  // Partial lane writes, then a deselected write changes nothing.
  task automatic s_mask();
    logic [1:0] m;
    exp0 = 18'h2A5C3;
    exp1 = 18'h15A3C;
    for (int i = 1; i < 4; i++) begin
      m = 2'(i);
      exp0 = merge(exp0, 18'h0F0F0 ^ 18'(i), m);
      exp1 = merge(exp1, 18'h30303 ^ 18'(i), m);
      xfer(1'b0, 1'b1, 8'h00, 8'h05, 18'h0F0F0 ^ 18'(i),
           18'h30303 ^ 18'(i), m);
      xfer(1'b1, 1'b0, 8'h05, 8'h00, 18'h0, 18'h0, 2'h3);
    end
    xfer(1'b0, 1'b0, 8'h00, 8'h05, 18'h11111, 18'h22222, 2'h0);
    xfer(1'b1, 1'b0, 8'h05, 8'h00, 18'h0, 18'h0, 2'h3);
  endtask

  // Single clock mode with the output strobes stopped.
  task automatic s_single();
    @(posedge clk) begin
      single_clk_mode <= 1'b1;
      out_stop <= 1'b1;
    end
    exp0 = 18'h3FFFF;
    exp1 = 18'h00001;
    xfer(1'b1, 1'b0, 8'hFF, 8'h00, 18'h0, 18'h0, 2'h3);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic final_report();
    $display("Checks %0d, errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Main sequence after a two cycle reset.
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    s_basic();
    s_legacy();
    s_mask();
    s_single();
    final_report();
  end

  // Watchdog well beyond the expected run of about eight hundred clocks.
  initial begin
    repeat (6000) @(posedge clk);
    errors++;
    final_report();
  end
endmodule
